// file: design/adccp_control.v
/*
 * Channel selection, reference and idle control, and top-priority
 * conversion sequencing for an on-chip converter, with an AHB-Lite
 * register port and one level interrupt.
 * Assumes a converter core that starts on convStart, stops at once on
 * convAbort, holds while convRun is low and pulses convDone with data.
 */
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "adccp_defines.vh"

module adccp_control (
	input  wire        core_clk,    // System clock, 20 MHz
	input  wire        srst,        // Synchronous reset, active high
	input  wire        hsel,        // AHB-Lite slave select
	input  wire [7:0]  haddr,       // AHB-Lite byte address
	input  wire [1:0]  htrans,      // AHB-Lite transfer type
	input  wire        hwrite,      // AHB-Lite write
	input  wire [2:0]  hsize,       // AHB-Lite size, word only
	input  wire [31:0] hwdata,      // AHB-Lite write data
	input  wire        hready,      // AHB-Lite bus ready
	output wire        hreadyout,   // Slave ready, always high
	output wire        hresp,       // Slave response, always OKAY
	output reg  [31:0] hrdata,      // Read data
	input  wire        idleMode,    // Chip is in IDLE mode
	input  wire        convDone,    // Converter finished, one-cycle pulse
	input  wire [11:0] convData,    // Converter result with convDone
	output wire        refEnable,   // Reference voltage applied
	output wire        convRun,     // Converter allowed to operate
	output reg         convStart,   // Start a conversion, one-cycle pulse
	output reg         convAbort,   // Abandon current conversion, pulse
	output reg  [3:0]  convChannel, // Analog input being converted
	output wire        irq          // Level interrupt
);

	localparam ST_IDLE = 2'h0;
	localparam ST_NORM = 2'h1;
	localparam ST_PRIO = 2'h2;

	reg  [7:0]  chanMode;
	reg         prioSpare;
	reg  [3:0]  prioChan;
	reg         prioPending;
	reg         prioBusy;
	reg         prioDone;
	reg         scanMode;
	reg         normActive;
	reg         normDone;
	reg  [3:0]  curChan;
	reg  [3:0]  endChan;
	reg  [1:0]  state;
	reg  [1:0]  intStatus;
	reg  [1:0]  intMask;
	reg  [11:0] prioResult;
	reg  [11:0] normResult;
	reg  [3:0]  normResultChan;
	reg  [6:0]  settleCount;
	reg         refReady;
	reg         wrPending;
	reg  [7:0]  wrAddr;
	reg  [31:0] next_hrdata;

	wire        addrPhase;
	wire        rdTaken;
	wire        wrNow;
	wire [3:0]  firstChan;
	wire [3:0]  lastChan;
	wire        prioStartWr;
	wire        normStartWr;
	wire        prioDoneEvt;
	wire        normDoneEvt;
	wire        rdPrio;
	wire        rdNorm;
	wire        rdIntStatus;

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	assign addrPhase   = hsel & htrans[1] & hready;
	assign rdTaken     = addrPhase & ~hwrite;
	assign wrNow       = wrPending;
	assign rdPrio      = rdTaken & (haddr == `ADCCP_OFS_PRIO_CTRL);
	assign rdNorm      = rdTaken & (haddr == `ADCCP_OFS_NORM_CTRL);
	assign rdIntStatus = rdTaken & (haddr == `ADCCP_OFS_INT_STATUS);

	assign prioStartWr = wrNow & (wrAddr == `ADCCP_OFS_PRIO_CTRL)
		& hwdata[`ADCCP_PRIO_START_BIT];
	assign normStartWr = wrNow & (wrAddr == `ADCCP_OFS_NORM_CTRL)
		& hwdata[`ADCCP_NORM_START_BIT];

	assign refEnable = chanMode[`ADCCP_REF_ENABLE_BIT];
	assign convRun   = ~idleMode | chanMode[`ADCCP_IDLE_OP_BIT];

	assign prioDoneEvt = (state == ST_PRIO) & convDone;
	assign normDoneEvt = (state == ST_NORM) & convDone & (curChan == endChan);

	assign irq = |(intStatus & intMask);

	adccp_scan_decode u_decode (
		.scanMode  (scanMode),
		.scanWidth (chanMode[`ADCCP_SCAN_W_HI:`ADCCP_SCAN_W_LO]),
		.chanField (chanMode[`ADCCP_CHAN_HI:`ADCCP_CHAN_LO]),
		.firstChan (firstChan),
		.lastChan  (lastChan)
	);

	// Write data follows its address phase by one cycle.
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			wrPending <= 1'b0;
			wrAddr    <= 8'h00;
		end
		else
		begin
			wrPending <= addrPhase & hwrite;
			if (addrPhase)
				wrAddr <= haddr;
		end
	end

	// Configuration registers.
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			chanMode  <= `ADCCP_RST_CHAN_MODE;
			prioSpare <= 1'b0;
			prioChan  <= 4'h0;
			scanMode  <= 1'b0;
			intMask   <= `ADCCP_RST_INT_MASK;
		end
		else if (wrNow)
		begin
			case (wrAddr)
				`ADCCP_OFS_CHAN_MODE:
					chanMode <= hwdata[7:0];
				`ADCCP_OFS_PRIO_CTRL:
				begin
					prioSpare <= hwdata[`ADCCP_PRIO_SPARE_BIT];
					prioChan  <= hwdata[3:0];
				end
				`ADCCP_OFS_NORM_CTRL:
					scanMode <= hwdata[`ADCCP_SCAN_MODE_BIT];
				`ADCCP_OFS_INT_MASK:
					intMask <= hwdata[1:0];
				default:
					chanMode <= chanMode;
			endcase
		end
	end

	// Reference settling: ready once enabled for the settle time.
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			settleCount <= 7'h00;
			refReady    <= 1'b0;
		end
		else if (!refEnable)
		begin
			settleCount <= 7'h00;
			refReady    <= 1'b0;
		end
		else if (settleCount == `ADCCP_REF_SETTLE_CYC)
			refReady <= 1'b1;
		else
			settleCount <= settleCount + 7'h01;
	end

	// Conversion sequencer; priority requests win over the normal sequence.
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			state       <= ST_IDLE;
			prioPending <= 1'b0;
			prioBusy    <= 1'b0;
			normActive  <= 1'b0;
			curChan     <= 4'h0;
			endChan     <= 4'h0;
			convStart   <= 1'b0;
			convAbort   <= 1'b0;
			convChannel <= 4'h0;
			prioResult  <= 12'h000;
			normResult  <= 12'h000;
			normResultChan <= 4'h0;
		end
		else
		begin
			convStart <= 1'b0;
			convAbort <= 1'b0;
			if (prioStartWr)
			begin
				prioPending <= 1'b1;
				prioBusy    <= 1'b1;
			end
			if (normStartWr)
			begin
				normActive <= 1'b1;
				curChan    <= firstChan;
				endChan    <= lastChan;
			end
			case (state)
				ST_IDLE:
				begin
					if (convRun && (prioPending || prioStartWr))
					begin
						prioPending <= 1'b0;
						// A start written while idle takes its channel from that same write.
						convChannel <= prioStartWr ? hwdata[3:0] : prioChan;
						convStart   <= 1'b1;
						state       <= ST_PRIO;
					end
					else if (convRun && normActive && !normStartWr)
					begin
						convChannel <= curChan;
						convStart   <= 1'b1;
						state       <= ST_NORM;
					end
				end
				ST_NORM:
				begin
					if (prioPending || prioStartWr)
					begin
						// The interrupted channel is redone afterwards.
						convAbort <= 1'b1;
						state     <= ST_IDLE;
					end
					else if (convDone)
					begin
						normResult     <= convData;
						normResultChan <= curChan;
						state          <= ST_IDLE;
						if (curChan == endChan)
							normActive <= 1'b0;
						else if (!normStartWr)
							curChan <= curChan + 4'h1;
					end
				end
				ST_PRIO:
				begin
					if (convDone)
					begin
						prioResult <= convData;
						if (!prioPending && !prioStartWr)
							prioBusy <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default:
					state <= ST_IDLE;
			endcase
		end
	end

	// Sticky flags: a completion in the same cycle as a read survives.
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			prioDone  <= 1'b0;
			normDone  <= 1'b0;
			intStatus <= 2'h0;
		end
		else
		begin
			if (prioDoneEvt)
				prioDone <= 1'b1;
			else if (rdPrio)
				prioDone <= 1'b0;
			if (normDoneEvt)
				normDone <= 1'b1;
			else if (rdNorm)
				normDone <= 1'b0;
			if (prioStartWr)
				prioDone <= 1'b0;
			intStatus[`ADCCP_INT_NORM_BIT] <= normDoneEvt
				| (intStatus[`ADCCP_INT_NORM_BIT] & ~rdIntStatus);
			intStatus[`ADCCP_INT_PRIO_BIT] <= prioDoneEvt
				| (intStatus[`ADCCP_INT_PRIO_BIT] & ~rdIntStatus);
		end
	end

	// Read data is prepared from the address phase.
	always @*
	begin
		next_hrdata = 32'h00000000;
		case (haddr)
			`ADCCP_OFS_CHAN_MODE:
				next_hrdata[7:0] = chanMode;
			`ADCCP_OFS_PRIO_CTRL:
			begin
				next_hrdata[`ADCCP_PRIO_DONE_BIT]  = prioDone;
				next_hrdata[`ADCCP_PRIO_BUSY_BIT]  = prioBusy;
				next_hrdata[`ADCCP_PRIO_START_BIT] = 1'b0;
				next_hrdata[`ADCCP_PRIO_SPARE_BIT] = prioSpare;
				next_hrdata[3:0] = prioChan;
			end
			`ADCCP_OFS_NORM_CTRL:
			begin
				next_hrdata[`ADCCP_NORM_DONE_BIT] = normDone;
				next_hrdata[`ADCCP_NORM_BUSY_BIT] = normActive;
				next_hrdata[`ADCCP_REF_READY_BIT] = refReady;
				next_hrdata[`ADCCP_SCAN_MODE_BIT] = scanMode;
			end
			`ADCCP_OFS_INT_STATUS:
				next_hrdata[1:0] = intStatus;
			`ADCCP_OFS_INT_MASK:
				next_hrdata[1:0] = intMask;
			`ADCCP_OFS_PRIO_RESULT:
				next_hrdata[11:0] = prioResult;
			`ADCCP_OFS_NORM_RESULT:
				next_hrdata[15:0] = {normResultChan, normResult};
			default:
				next_hrdata = 32'h00000000;
		endcase
	end

	always @(posedge core_clk)
	begin
		if (srst)
			hrdata <= 32'h00000000;
		else if (rdTaken)
			hrdata <= next_hrdata;
	end

endmodule // adccp_control

// file: design/adccp_defines.vh
/*
 * Constants of the converter channel and priority control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes it is included once per file by its bare name.
 */
`ifndef ADCCP_DEFINES_VH
`define ADCCP_DEFINES_VH

// Byte offsets on the AHB-Lite register port.
`define ADCCP_OFS_CHAN_MODE   8'h00
`define ADCCP_OFS_PRIO_CTRL   8'h04
`define ADCCP_OFS_NORM_CTRL   8'h08
`define ADCCP_OFS_INT_STATUS  8'h0c
`define ADCCP_OFS_INT_MASK    8'h10
`define ADCCP_OFS_PRIO_RESULT 8'h14
`define ADCCP_OFS_NORM_RESULT 8'h18

// channel_select_mode fields.
`define ADCCP_REF_ENABLE_BIT  7
`define ADCCP_IDLE_OP_BIT     6
`define ADCCP_SCAN_W_HI       5
`define ADCCP_SCAN_W_LO       4
`define ADCCP_CHAN_HI         3
`define ADCCP_CHAN_LO         0

// priority_conversion_control fields.
`define ADCCP_PRIO_DONE_BIT   7
`define ADCCP_PRIO_BUSY_BIT   6
`define ADCCP_PRIO_START_BIT  5
`define ADCCP_PRIO_SPARE_BIT  4

// Normal conversion control fields.
`define ADCCP_NORM_DONE_BIT   7
`define ADCCP_NORM_BUSY_BIT   6
`define ADCCP_REF_READY_BIT   5
`define ADCCP_SCAN_MODE_BIT   1
`define ADCCP_NORM_START_BIT  0

// Interrupt status and mask bits.
`define ADCCP_INT_NORM_BIT    0
`define ADCCP_INT_PRIO_BIT    1

// Scan width encodings.
`define ADCCP_SCAN_4          2'h0
`define ADCCP_SCAN_8          2'h1
`define ADCCP_SCAN_12         2'h2

// Reset values.
`define ADCCP_RST_CHAN_MODE   8'h00
`define ADCCP_RST_PRIO_CTRL   8'h00
`define ADCCP_RST_INT_MASK    2'h0

// Reference settling time and its count at the core clock.
`define ADCCP_REF_SETTLE_NS   3000
`define ADCCP_CLK_PERIOD_NS   50
`define ADCCP_REF_SETTLE_CYC  7'd60

`endif

// file: design/adccp_scan_decode.v
/*
 * Decodes the channel field and scan settings into the first and last
 * analog input of a conversion sequence.
 * Assumes the fields come straight from the mode registers.
 */
`timescale 1ns/100ps
`include "adccp_defines.vh"

module adccp_scan_decode (
	input  wire       scanMode,   // 1 selects channel scan
	input  wire [1:0] scanWidth,  // Scan width field
	input  wire [3:0] chanField,  // Channel field
	output reg  [3:0] firstChan,  // First input of the sequence
	output reg  [3:0] lastChan    // Last input of the sequence
);

	always @*
	begin
		firstChan = 4'h0;
		lastChan  = chanField;
		if (!scanMode)
		begin
			// Fixed channel: width is ignored, one input only.
			firstChan = chanField;
			lastChan  = chanField;
		end
		else
		begin
			case (scanWidth)
				`ADCCP_SCAN_4:
				begin
					firstChan = {1'b0, chanField[2], 2'h0};
					lastChan  = {1'b0, chanField[2], chanField[1:0]};
				end
				`ADCCP_SCAN_8:
				begin
					lastChan = {1'b0, chanField[2:0]};
				end
				`ADCCP_SCAN_12:
				begin
					lastChan = chanField;
				end
				default:
				begin
					// Reserved width: fall back to a single channel.
					firstChan = chanField;
					lastChan  = chanField;
				end
			endcase
		end
	end

endmodule // adccp_scan_decode

// file: verification/adc_channel_and_priority_control_bench.sv
/* Self-checking bench of the converter control block.
   Assumes the slave answers every transfer without wait states. */
`timescale 1ns/100ps
`include "adccp_defines.vh"
module adc_channel_and_priority_control_bench;
	typedef struct packed {logic sm; logic [1:0] sw; logic [3:0] ch, f, l;} adccp_row_t;
	localparam [7:0]	OCM = `ADCCP_OFS_CHAN_MODE;
	localparam [7:0]	OPC = `ADCCP_OFS_PRIO_CTRL;
	localparam [7:0]	ONC = `ADCCP_OFS_NORM_CTRL;
	localparam [7:0]	OIS = `ADCCP_OFS_INT_STATUS;
	reg		core_clk = 1'b0;
	reg		srst = 1'b1;
	reg		hsel = 1'b0;
	reg [7:0]	haddr = 8'h00;
	reg [1:0]	htrans = 2'h0;
	reg		hwrite = 1'b0;
	reg [31:0]	hwdata = 32'h0;
	reg		idleMode = 1'b0;
	reg		convDone = 1'b0;
	reg [11:0]	convData = 12'h000;
	wire		hreadyout;
	wire		hresp;
	wire [31:0]	hrdata;
	wire		refEnable;
	wire		convRun;
	wire		convStart;
	wire		convAbort;
	wire [3:0]	convChannel;
	wire		irq;
	integer		miscompares = 0;
	integer		checkCount = 0;
	integer		k;
	integer		c;
	reg [31:0]	d;
	adccp_row_t	r;
	adccp_row_t	rows [0:5] = '{{1'b0, 2'h1, 4'h9, 4'h9, 4'h9}, {1'b1, 2'h0, 4'h6, 4'h4, 4'h6},
		{1'b1, 2'h0, 4'hb, 4'h0, 4'h3}, {1'b1, 2'h1, 4'hd, 4'h0, 4'h5},
		{1'b1, 2'h2, 4'hb, 4'h0, 4'hb}, {1'b0, 2'h0, 4'hf, 4'hf, 4'hf}};
	reg [7:0]	ra [0:3] = '{OCM, OPC, `ADCCP_OFS_INT_MASK, 8'h1c};
	adccp_control dut_u (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .idleMode(idleMode), .convDone(convDone), .convData(convData),
		.refEnable(refEnable), .convRun(convRun), .convStart(convStart), .convAbort(convAbort),
		.convChannel(convChannel), .irq(irq));
	initial
		forever #25 core_clk = ~core_clk;
	task chk(input [63:0] n, input [31:0] e, input [31:0] g);
	begin
		checkCount = checkCount + 1;
		if (e !== g)
		begin
			miscompares = miscompares + 1;
			$display("BAD %0s expected %h seen %h", n, e, g);
		end
	end
	endtask
	task bus(input w, input [7:0] a, input [31:0] v);
	begin
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge core_clk);
		while (hreadyout !== 1'b1)
			@(posedge core_clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= v;
		@(posedge core_clk);
		while (hreadyout !== 1'b1)
			@(posedge core_clk);
		d = hrdata;
	end
	endtask
	// Waits for one start, checks its input, then answers with a done pulse.
	task cv(input [3:0] ch);
		integer i;
	begin
		i = 0;
		@(posedge core_clk);
		while (convStart !== 1'b1 && i < 99)
		begin
			@(posedge core_clk);
			i = i + 1;
		end
		chk("start", 32'h1, {31'h0, convStart});
		chk("chan", {28'h0, ch}, {28'h0, convChannel});
		convDone <= 1'b1;
		convData <= {8'h00, ch};
		@(posedge core_clk);
		convDone <= 1'b0;
	end
	endtask
	task giveVerdict;
	begin
		$display("checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		bus(1'b1, OCM, 32'h80);
		repeat (60) @(posedge core_clk);
		for (k = 0; k < 6; k = k + 1)
		begin
			r = rows[k];
			bus(1'b1, OCM, {24'h0, 2'b10, r.sw, r.ch});
			bus(1'b1, ONC, {30'h0, r.sm, 1'b0});
			bus(1'b1, ONC, {30'h0, r.sm, 1'b1});
			for (c = r.f; c <= r.l; c = c + 1)
				cv(c[3:0]);
		end
		$display("test scan done");
		bus(1'b0, OIS, 32'h0);
		for (k = 1; k >= 0; k = k - 1)
		begin
			c = 5 + 5 * k;
			bus(1'b1, `ADCCP_OFS_INT_MASK, k << 1);
			// Idle mode holds the first start pending so its busy flag can be read.
			idleMode <= k[0];
			bus(1'b1, OPC, 32'h20 + c);
			if (k == 1)
			begin
				bus(1'b0, OPC, 32'h0);
				chk("busy", 32'h40 + c, d);
				idleMode <= 1'b0;
			end
			cv(c[3:0]);
			@(posedge core_clk);
			chk("irq", k, {31'h0, irq});
			bus(1'b0, OPC, 32'h0);
			chk("done", 32'h80 + c, d);
			bus(1'b0, OPC, 32'h0);
			chk("clear", c, d);
			bus(1'b0, OIS, 32'h0);
			chk("status", 32'h2, d);
			@(posedge core_clk);
			chk("irqoff", 32'h0, {31'h0, irq});
		end
		bus(1'b1, OPC, 32'h0a);
		bus(1'b0, OPC, 32'h0);
		chk("nostart", 32'h0a, d);
		$display("test priority done");
		bus(1'b1, OCM, 32'h83);
		bus(1'b1, ONC, 32'h2);
		bus(1'b1, ONC, 32'h3);
		cv(4'h0);
		bus(1'b1, OPC, 32'h2c);
		cv(4'hc);
		for (c = 1; c < 4; c = c + 1)
			cv(c[3:0]);
		$display("test preempt done");
		for (k = 0; k < 4; k = k + 1)
		begin
			bus(1'b1, OCM, k << 6);
			idleMode <= 1'b1;
			@(posedge core_clk);
			chk("ref", k >> 1, {31'h0, refEnable});
			chk("run", k & 1, {31'h0, convRun});
			idleMode <= 1'b0;
		end
		$display("test idle done");
		srst <= 1'b1;
		repeat (10) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		chk("ref0", 32'h0, {31'h0, refEnable});
		chk("hresp", 32'h0, {31'h0, hresp});
		bus(1'b1, 8'h1c, 32'hffffffff);
		for (k = 0; k < 4; k = k + 1)
		begin
			bus(1'b0, ra[k], 32'h0);
			chk("reset", 32'h0, d);
		end
		$display("test reset done");
		giveVerdict;
	end
	initial
	begin
		repeat (6000) @(posedge core_clk);
		miscompares = miscompares + 1;
		giveVerdict;
	end
endmodule // adc_channel_and_priority_control_bench

// file: verification/adccp_control_props.sv
/* Port assertions for the converter control block.
   Assumes one clock, a zero-wait slave and a bench that toggles idleMode only while quiet. */
`timescale 1ns/100ps
`include "adccp_defines.vh"
module adccp_control_props (
	input wire		core_clk,	// Clock
	input wire		srst,		// Reset
	input wire		hsel,		// Select
	input wire [7:0]	haddr,		// Address
	input wire [1:0]	htrans,		// Type
	input wire		hwrite,		// Write
	input wire [31:0]	hwdata,		// Wdata
	input wire		hready,		// Ready
	input wire [31:0]	hrdata,		// Rdata
	input wire		idleMode,	// Idle
	input wire		convDone,	// Done
	input wire		refEnable,	// Ref
	input wire		convRun,	// Run
	input wire		convStart,	// Start
	input wire		convAbort,	// Abort
	input wire [3:0]	convChannel	// Input
);
	reg		aWr;
	reg		aRd;
	reg [7:0]	aAd;
	reg [3:0]	pCh;
	reg		pRun;
	wire		wrChan = aWr && aAd == `ADCCP_OFS_CHAN_MODE && hready;
	wire		wrPrio = aWr && aAd == `ADCCP_OFS_PRIO_CTRL && hready;
	wire		rdPrio = aRd && aAd == `ADCCP_OFS_PRIO_CTRL && hready;
	// Track the address phase so the data phase can be judged.
	always @(posedge core_clk)
	begin
		if (srst)
		begin
			aWr <= 1'b0;
			aRd <= 1'b0;
			pRun <= 1'b0;
		end
		else
		begin
			if (hready)
			begin
				aWr <= hsel && htrans[1] && hwrite;
				aRd <= hsel && htrans[1] && !hwrite;
			end
			if (wrPrio && hwdata[5])
				pRun <= 1'b1;
			else if (convDone)
				pRun <= 1'b0;
		end
		if (hready)
			aAd <= haddr;
		if (wrPrio)
			pCh <= hwdata[3:0];
	end
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (srst);
	sequence sPrioReq;
		wrPrio && hwdata[5] && convRun;
	endsequence
	sequence sPrioGo;
		convStart && convChannel == pCh;
	endsequence
	a_ref_follows: assert property (wrChan |=> refEnable == $past(hwdata[7]))
		else $error("reference enable does not follow its bit");
	a_idle_mode: assert property (wrChan |=> convRun == (!idleMode || $past(hwdata[6])))
		else $error("run does not follow idle setting");
	a_idle_free: assert property (!idleMode |-> convRun)
		else $error("converter stopped outside idle");
	a_no_run: assert property (!convRun |-> !convStart)
		else $error("start while stopped");
	a_prio_go: assert property (sPrioReq |-> ##[1:4] sPrioGo)
		else $error("priority start missing or wrong input");
	a_abort_first: assert property (convAbort |-> ##[1:3] sPrioGo)
		else $error("abort not followed by priority start");
	a_start_pulse: assert property (convStart |=> !convStart)
		else $error("start longer than one cycle");
	a_start_reads0: assert property (rdPrio |-> hrdata[5] == 1'b0 && hrdata[31:8] == 24'h0)
		else $error("priority start bit read as one");
	a_busy_shown: assert property (rdPrio && $past(pRun) |-> hrdata[6] && !hrdata[7])
		else $error("busy or done wrong during priority");
endmodule // adccp_control_props
bind adccp_control adccp_control_props chk_u (.core_clk(core_clk), .srst(srst), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .idleMode(idleMode),
	.convDone(convDone), .refEnable(refEnable), .convRun(convRun), .convStart(convStart),
	.convAbort(convAbort), .convChannel(convChannel));
